/* bsc_chain.sv */
`timescale 1ns/1ps
// Contract
// - Each port pin: pull-up cell plus two-stage output-control/data/input pin cell
// - Without alternate function: input through two-stage synchroniser, data from port, control from direction
// - Pull-up enable is not-disable and not-direction and port output bit
// - Alternate digital functions sit outside cells; chain samples the true pin
// - Analog pins bypass chain; cells sit on digital-analog boundary signals
// - Two-wire pins add one general cell on the slew-limited driver enable
// - No scan cell for the two-wire spike filter; ordinary pin cells suffice
// - Reset pin has observe-only cells for normal and high-voltage reset
// - Oscillator enables use general cells; clock outputs use observe-only cells
// - Internal RC oscillator output is not in the chain
// - Unused clock lines read fixed level: low-frequency high, others low
// - Oscillator enables are in chain so sleep cannot drop them
// - Internal-capacitor setting is not scan-controllable
// - Shift registers move least significant bit in and out first
// - External test drives pins from latches at once; Update-DR refreshes them
module bsc_chain
   import bsc_pkg::*;
#(
   parameter int NumPins = NUM_PINS,
   parameter logic [NUM_OSC-1:0] UnusedLevel = OSC_UNUSED_LEVEL
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Test access port side
   input wire logic tck,
   input wire logic tdi,
   output logic tdo,
   input wire logic captureDr,
   input wire logic shiftDr,
   input wire logic updateDr,
   input wire logic external_test_instruction,
   // Functional port logic
   input wire logic global_pullup_disable,
   input wire logic [NumPins-1:0] pin_direction_bit,
   input wire logic [NumPins-1:0] port_output_register_bit,
   output logic [NumPins-1:0] pin_level_register_bit,
   // Pads
   input wire logic [NumPins-1:0] padIn,
   output logic [NumPins-1:0] padOut,
   output logic [NumPins-1:0] padOe_n,
   output logic [NumPins-1:0] pin_pullup_enable,
   // Two-wire interface enables for clock and data pins
   input wire logic [1:0] twiEnFunc,
   output logic [1:0] two_wire_driver_enable,
   // Reset pin detectors
   input wire logic normal_reset_observe,
   input wire logic high_voltage_reset_observe,
   // Oscillators: enables out, clock lines in
   input wire logic [NUM_OSC-1:0] oscEnFunc,
   output logic [NUM_OSC-1:0] oscEnable,
   input wire logic [NUM_OSC-1:0] oscClockLine,
   input wire logic [NUM_OSC-1:0] oscOptionUsed
);
   // Chain map: no internal RC slot, two-wire enables only, no filter cell
   localparam int Len = NumPins * PIN_CELLS + TWI_CELLS + RST_CELLS + OSC_CELLS;
   localparam int TwiBase = NumPins * PIN_CELLS;
   localparam int RstBase = TwiBase + TWI_CELLS;
   localparam int OscBase = RstBase + RST_CELLS;

   bsc_tap_if tap();

   bsc_tck_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .tck(tck),
      .tdi(tdi),
      .captureDr(captureDr),
      .shiftDr(shiftDr),
      .updateDr(updateDr),
      .extestSelect(external_test_instruction),
      .tap(tap)
   );

   typedef struct packed {
      logic [Len-1:0] shift;
      logic [Len-1:0] latch;
      logic tdoOut;
      logic [NumPins-1:0] padMeta;
      logic [NumPins-1:0] padSync;
      logic [1:0] rstMeta;
      logic [1:0] rstSync;
      logic [NUM_OSC-1:0] oscMeta;
      logic [NUM_OSC-1:0] oscSync;
   } bsc_chain_s;

   bsc_chain_s state_reg;
   bsc_chain_s state_next;

   // Chain positions of a pin's three cells
   function automatic int pullCell(input int p);
      return p * PIN_CELLS;
   endfunction
   function automatic int ctrlCell(input int p);
      return p * PIN_CELLS + 1;
   endfunction
   function automatic int dataCell(input int p);
      return p * PIN_CELLS + 2;
   endfunction

   // Pull-up request from port registers
   logic [NumPins-1:0] pullFunc;
   assign pullFunc = {NumPins{~global_pullup_disable}} & ~pin_direction_bit
                     & port_output_register_bit;

   // Scanned clock lines read fixed level when option unused
   logic [NUM_OSC-1:0] clockSeen;
   assign clockSeen = (state_reg.oscSync & oscOptionUsed)
                      | (UnusedLevel & ~oscOptionUsed);

   // Parallel capture vector, one bit per cell
   logic [Len-1:0] capVec;
   always_comb begin
      capVec = '0;
      for (int p = 0; p < NumPins; p++) begin
         capVec[pullCell(p)] = pullFunc[p];
         capVec[ctrlCell(p)] = pin_direction_bit[p];
         // Pin cell sees the pad itself, never an alternate function's value
         capVec[dataCell(p)] = state_reg.padSync[p];
      end
      capVec[TwiBase +: TWI_CELLS] = twiEnFunc;
      capVec[RstBase] = state_reg.rstSync[0];
      capVec[RstBase + 1] = state_reg.rstSync[1];
      for (int o = 0; o < NUM_OSC; o++) begin
         capVec[OscBase + 2 * o] = oscEnFunc[o];
         capVec[OscBase + 2 * o + 1] = clockSeen[o];
      end
   end

   // Capture, shift toward bit 0, and update on tck edges
   always_comb begin
      state_next = state_reg;
      if (clkEn) begin
         state_next.padMeta = padIn;
         state_next.padSync = state_reg.padMeta;
         state_next.rstMeta = {high_voltage_reset_observe, normal_reset_observe};
         state_next.rstSync = state_reg.rstMeta;
         state_next.oscMeta = oscClockLine;
         state_next.oscSync = state_reg.oscMeta;
         if (tap.tckRise) begin
            if (tap.captureSync) begin
               state_next.shift = capVec;
            end else if (tap.shiftSync) begin
               state_next.shift = {tap.tdiSync, state_reg.shift[Len-1:1]};
            end
         end
         if (tap.tckFall) begin
            state_next.tdoOut = state_reg.shift[0];
            if (tap.updateSync) begin
               state_next.latch = state_reg.shift;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Output muxes: latches drive under external test, function otherwise
   logic ext;
   assign ext = tap.extestSync;
   always_comb begin
      for (int p = 0; p < NumPins; p++) begin
         pin_pullup_enable[p] = ext ? state_reg.latch[pullCell(p)] : pullFunc[p];
         padOut[p] = ext ? state_reg.latch[dataCell(p)]
                         : port_output_register_bit[p];
         // Active-low enable: drive when direction bit set
         padOe_n[p] = ext ? ~state_reg.latch[ctrlCell(p)]
                          : ~pin_direction_bit[p];
      end
      two_wire_driver_enable = ext ? state_reg.latch[TwiBase +: TWI_CELLS]
                                   : twiEnFunc;
      // Only enables are scanned; capacitor setting stays with its fuses
      for (int o = 0; o < NUM_OSC; o++) begin
         oscEnable[o] = ext ? state_reg.latch[OscBase + 2 * o] : oscEnFunc[o];
      end
   end

   // Input data is the pad level after the two-stage padMeta/padSync synchroniser
   assign pin_level_register_bit = state_reg.padSync;
   assign tdo = state_reg.tdoOut;
endmodule

/* bsc_pkg.sv */
package bsc_pkg;
   // Number of bidirectional port pins covered by the chain
   localparam int NUM_PINS = 8;
   // Number of oscillator enable/clock pairs
   localparam int NUM_OSC = 5;
   // Oscillator slot order inside the chain
   localparam int OSC_EXT_CLOCK = 0;
   localparam int OSC_CRYSTAL = 1;
   localparam int OSC_EXT_RC = 2;
   localparam int OSC_LOW_FREQ = 3;
   localparam int OSC_TIMER = 4;
   // Fixed level of each scanned clock line when its option is unused
   localparam logic [NUM_OSC-1:0] OSC_UNUSED_LEVEL = 5'h08;
   // Cells per port pin: pull-up cell plus two-stage pin cell
   localparam int PIN_CELLS = 3;
   // Cells for two-wire enables, reset observers, oscillator pairs
   localparam int TWI_CELLS = 2;
   localparam int RST_CELLS = 2;
   localparam int OSC_CELLS = 2 * NUM_OSC;
   localparam int CHAIN_LEN = NUM_PINS * PIN_CELLS + TWI_CELLS + RST_CELLS + OSC_CELLS;
   // Reset value of all chain and latch bits
   localparam logic CELL_RESET = 1'b0;
endpackage

/* bsc_tap_if.sv */
`timescale 1ns/1ps
// Link-side strobes shared between the chain and its tck front end
interface bsc_tap_if;
   logic tckRise;
   logic tckFall;
   logic tdiSync;
   logic captureSync;
   logic shiftSync;
   logic updateSync;
   logic extestSync;
   modport front (
      output tckRise,
      output tckFall,
      output tdiSync,
      output captureSync,
      output shiftSync,
      output updateSync,
      output extestSync
   );
   modport chain (
      input tckRise,
      input tckFall,
      input tdiSync,
      input captureSync,
      input shiftSync,
      input updateSync,
      input extestSync
   );
endinterface

/* bsc_tck_sync.sv */
`timescale 1ns/1ps
// Synchronises the test clock and strobes, finds tck edges
module bsc_tck_sync
   import bsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic tck,
   input wire logic tdi,
   input wire logic captureDr,
   input wire logic shiftDr,
   input wire logic updateDr,
   input wire logic extestSelect,
   bsc_tap_if.front tap
);
   typedef struct packed {
      logic [4:0] meta;
      logic [4:0] sync;
      logic tckLast;
      logic tdiMeta;
      logic tdiSync;
   } bsc_sync_s;

   bsc_sync_s state_reg;
   bsc_sync_s state_next;

   // Two stages per input; only stage two feeds any logic
   always_comb begin
      state_next = state_reg;
      if (clkEn) begin
         state_next.meta = {extestSelect, updateDr, shiftDr, captureDr, tck};
         state_next.sync = state_reg.meta;
         state_next.tckLast = state_reg.sync[0];
         // Same two stages as tck, so tdi lines up with the detected rise
         state_next.tdiMeta = tdi;
         state_next.tdiSync = state_reg.tdiMeta;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Edge pulses are one clk cycle wide and gated by the enable
   assign tap.tckRise = clkEn & state_reg.sync[0] & ~state_reg.tckLast;
   assign tap.tckFall = clkEn & ~state_reg.sync[0] & state_reg.tckLast;
   assign tap.tdiSync = state_reg.tdiSync;
   assign tap.captureSync = state_reg.sync[1];
   assign tap.shiftSync = state_reg.sync[2];
   assign tap.updateSync = state_reg.sync[3];
   assign tap.extestSync = state_reg.sync[4];
endmodule

/* bsc_tester.sv */
`timescale 1ns/1ps
// Tester end of the scan link; strobes move only while tck is low
module bsc_tester
   import bsc_pkg::*;
(
   input wire logic clk,
   input wire logic tdo,
   output logic tck,
   output logic tdi,
   output logic captureDr,
   output logic shiftDr,
   output logic updateDr
);
   initial {tck, tdi, captureDr, shiftDr, updateDr} = '0;

   // One tck period of 40 clocks; tdo read before the rise
   task automatic pulse(input logic d, output logic q);
      q = tdo;
      tdi <= d;
      repeat (10) @(posedge clk);
      tck <= 1'b1;
      repeat (20) @(posedge clk);
      tck <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   // Capture, shift the whole chain, then update the latches
   task automatic scan(input logic [CHAIN_LEN-1:0] din, output logic [CHAIN_LEN-1:0] dout);
      logic q;
      @(posedge clk);
      captureDr <= 1'b1;
      pulse(1'b0, q);
      captureDr <= 1'b0;
      shiftDr <= 1'b1;
      for (int i = 0; i < CHAIN_LEN; i++) begin
         pulse(din[i], q);
         dout[i] = q;
      end
      shiftDr <= 1'b0;
      updateDr <= 1'b1;
      pulse(1'b0, q);
      updateDr <= 1'b0;
   endtask
endmodule

/* bsc_chain_chk.sv */
`timescale 1ns/1ps
// Pin-side muxes, latch holding and tdo timing of the chain
module bsc_chain_chk
   import bsc_pkg::*;
#(
   parameter int NumPins = NUM_PINS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tck,
   input wire logic tdo,
   input wire logic updateDr,
   input wire logic external_test_instruction,
   input wire logic global_pullup_disable,
   input wire logic [NumPins-1:0] pin_direction_bit,
   input wire logic [NumPins-1:0] port_output_register_bit,
   input wire logic [NumPins-1:0] pin_level_register_bit,
   input wire logic [NumPins-1:0] padIn,
   input wire logic [NumPins-1:0] padOut,
   input wire logic [NumPins-1:0] padOe_n,
   input wire logic [NumPins-1:0] pin_pullup_enable,
   input wire logic [1:0] twiEnFunc,
   input wire logic [1:0] two_wire_driver_enable,
   input wire logic [NUM_OSC-1:0] oscEnFunc,
   input wire logic [NUM_OSC-1:0] oscEnable
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Select is synchronised, so allow it to settle first
   sequence funcMode;
      (!external_test_instruction) [*4];
   endsequence
   sequence latchQuiet;
      (external_test_instruction && !updateDr) [*8];
   endsequence
   pullup_fn_a: assert property (funcMode |-> pin_pullup_enable ==
      (~{NumPins{global_pullup_disable}} & ~pin_direction_bit & port_output_register_bit))
      else $error("pull-up enable wrong");
   pad_fn_a: assert property (funcMode |->
      padOut == port_output_register_bit && padOe_n == ~pin_direction_bit)
      else $error("pad drive wrong");
   twi_fn_a: assert property (funcMode |-> two_wire_driver_enable == twiEnFunc)
      else $error("two-wire enable wrong");
   osc_fn_a: assert property (funcMode |-> oscEnable == oscEnFunc)
      else $error("oscillator enable wrong");
   pin_sync_a: assert property ($past(reset_n, 2) && $past(reset_n) |->
      pin_level_register_bit == $past(padIn, 2))
      else $error("pin level wrong");
   tdo_fall_a: assert property ($changed(tdo) |-> !$past(tck, 2))
      else $error("tdo moved off a tck fall");
   latch_pad_a: assert property (latchQuiet |-> $stable(padOut) && $stable(padOe_n))
      else $error("pad latch moved");
   latch_en_a: assert property (latchQuiet |-> $stable(pin_pullup_enable) &&
      $stable(oscEnable) && $stable(two_wire_driver_enable))
      else $error("enable latch moved");
endmodule

bind bsc_chain bsc_chain_chk #(.NumPins(NumPins)) u_bsc_chain_chk (.*);

/* bsc_chain_tb.sv */
`timescale 1ns/1ps
module bsc_chain_tb
   import bsc_pkg::*;
();
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ext = 1'b0;
   logic gpd = 1'b0;
   logic tck, tdi, tdo, captureDr, shiftDr, updateDr;
   logic [NUM_PINS-1:0] dir = '0, port = '0, padIn = '0, lvl, padOut, padOe_n, pu;
   logic [1:0] twiEnFunc = '0, twiOut;
   logic [NUM_OSC-1:0] oscEnFunc = '0, oscEnable;
   // Static external clock levels, never a drifting oscillator
   logic [NUM_OSC-1:0] oscClockLine = 5'h15, oscOptionUsed = 5'h06;
   int numErrors = 0, compares = 0, cycles = 0;
   logic [CHAIN_LEN-1:0] pat, got, capExp;

   bsc_chain u_bsc_chain (.*, .clkEn(1'b1), .external_test_instruction(ext),
      .global_pullup_disable(gpd), .pin_direction_bit(dir), .port_output_register_bit(port),
      .pin_level_register_bit(lvl), .pin_pullup_enable(pu), .two_wire_driver_enable(twiOut),
      .normal_reset_observe(1'b1), .high_voltage_reset_observe(1'b0));
   bsc_tester u_bsc_tester (.*);

   always #2 clk = ~clk;

   task automatic reportAndStop();
      $display("errors %0d compares %0d", numErrors, compares);
      if (numErrors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [CHAIN_LEN-1:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         numErrors++;
         $display("unexpected %s exp %h seen %h", what, exp, seen);
      end
   endtask

   // Pin outputs must follow the update latches
   task automatic checkLatch(input logic [CHAIN_LEN-1:0] v);
      for (int p = 0; p < NUM_PINS; p++)
         check("pin", {padOut[p], ~padOe_n[p], pu[p]}, v[3*p +: 3]);
      check("twi", twiOut, v[25:24]);
      for (int o = 0; o < NUM_OSC; o++)
         check("osc", oscEnable[o], v[28+2*o]);
   endtask

   // Hang guard, far above the two scan passes
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         numErrors++;
         reportAndStop();
      end
   end

   // Functional muxes first, then capture and two update passes
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         gpd <= k[2];
         dir <= 8'h33 << k;
         port <= 8'h5A ^ {8{k[0]}};
         padIn <= 8'hA5 ^ 8'(k);
         twiEnFunc <= 2'(k);
         oscEnFunc <= 5'h01 << (k % 5);
         repeat (4) @(posedge clk);
         #1;
         check("pullup", pu, 8'(~{8{gpd}} & ~dir & port));
         check("pads", {padOut, padOe_n, lvl}, {port, ~dir, padIn});
         check("enables", {twiOut, oscEnable}, {twiEnFunc, oscEnFunc});
      end
      @(posedge clk);
      gpd <= 1'b0;
      #1;
      for (int p = 0; p < NUM_PINS; p++)
         capExp[3*p +: 3] = {padIn[p], dir[p], ~gpd & ~dir[p] & port[p]};
      capExp[27:24] = {2'b01, twiEnFunc};
      for (int o = 0; o < NUM_OSC; o++)
         capExp[28+2*o +: 2] = {oscOptionUsed[o] ? oscClockLine[o] : OSC_UNUSED_LEVEL[o],
            oscEnFunc[o]};
      for (int s = 0; s < 2; s++) begin
         for (int p = 0; p < NUM_PINS; p++)
            pat[3*p +: 3] = s ? {p[0], 1'b0, p[1]} : {p[0], p[1], ~p[0]};
         pat[37:24] = s ? 14'h0403 : 14'h0040;
         u_bsc_tester.scan(pat, got);
         #1;
         if (s == 0) begin
            check("chain", got, capExp);
            check("functional", padOut, port);
            @(posedge clk);
            ext <= 1'b1;
            repeat (5) @(posedge clk);
            #1;
         end
         checkLatch(pat);
      end
      reportAndStop();
   end
endmodule
